// ==== common/pbw_pkg.sv ====
// shared constants and types of the peripheral bus wait bridge
package pbw_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int WAIT_W = 8;

  // peripheral registers that need special wait handling
  localparam logic [ADDR_W-1:0] ADDR_ASYNC_SERIAL0_RX_STATUS = 16'hff20;
  localparam logic [ADDR_W-1:0] ADDR_ASYNC_SERIAL6_RX_STATUS = 16'hff21;
  localparam logic [ADDR_W-1:0] ADDR_TWO_WIRE_SERIAL_STATUS = 16'hff22;
  localparam logic [ADDR_W-1:0] ADDR_CONVERTER_MODE_REG = 16'hff28;

  // wait clocks
  localparam logic [WAIT_W-1:0] FIXED_WAIT = 8'h01;
  localparam logic [WAIT_W-1:0] CONV_WAIT_MIN = 8'h01;
  localparam logic [WAIT_W-1:0] CONV_WAIT_MAX = 8'h05;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 8'h00;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 8'h01;
  localparam logic [WAIT_W-1:0] WAIT_SAT = 8'hff;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic we;
    logic [DATA_W-1:0] wdata;
  } pbw_access_t;

  typedef enum logic [1:0] {
    KIND_FIXED,
    KIND_HSK
  } pbw_kind_t;
endpackage

// ==== hw/pbw_sync.sv ====
// two flip-flop synchroniser for levels and stable words
`timescale 1ns/1ps
`default_nettype none
module pbw_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pbw_sync
`default_nettype wire

// ==== hw/pbw_bridge.sv ====
// processor to peripheral bus bridge with wait generation
// Operation
// (RULE_01) separate processor-side and peripheral-side buses; accesses cross between them
// (RULE_02) bus clocks asynchronous; colliding access must never deliver corrupted data
// (RULE_03) conflicting access waits until correct data passed, then completes
// (RULE_04) no next instruction during wait; clock count grows by wait clocks
// (RULE_05) reads of three serial status registers insert exactly one wait clock
// (RULE_06) converter mode register write inserts one to five wait clocks; bridge waits for handshake, flags conv_wait_overrun outside range
// (RULE_07) wait made on processor clock, released after resynchronised peripheral handshake
`timescale 1ns/1ps
`default_nettype none
module pbw_bridge (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // processor side
  input wire logic cpu_req,
  input wire pbw_pkg::pbw_access_t cpu_acc,
  output logic cpu_wait,
  output logic cpu_ready,
  output logic [pbw_pkg::DATA_W-1:0] cpu_rdata,
  output logic [pbw_pkg::WAIT_W-1:0] last_wait,
  output logic conv_wait_overrun,
  // peripheral side handshake
  output logic per_req_tgl,
  output var pbw_pkg::pbw_access_t per_acc,
  input wire logic per_ack_tgl,
  input wire logic [pbw_pkg::DATA_W-1:0] per_rdata,
  // status registers from the peripheral domain
  input wire logic [pbw_pkg::DATA_W-1:0] async_serial0_rx_status,
  input wire logic [pbw_pkg::DATA_W-1:0] async_serial6_rx_status,
  input wire logic [pbw_pkg::DATA_W-1:0] two_wire_serial_status
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIXED,
    ST_HSK,
    ST_DONE
  } pbw_state_t;

  localparam int SYNC_W = 4 * pbw_pkg::DATA_W + 1;

  pbw_state_t state;
  pbw_pkg::pbw_kind_t kind;
  logic ack_s;
  logic ack_seen;
  logic ack_new;
  logic [pbw_pkg::DATA_W-1:0] rdata_s;
  logic [pbw_pkg::DATA_W-1:0] stat0_s;
  logic [pbw_pkg::DATA_W-1:0] stat6_s;
  logic [pbw_pkg::DATA_W-1:0] stat_tw_s;
  logic [pbw_pkg::WAIT_W-1:0] wait_run;
  logic [pbw_pkg::WAIT_W-1:0] next_wait_run;
  logic conv_access;

  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // access class decode
  function automatic pbw_pkg::pbw_kind_t classify(
    input pbw_pkg::pbw_access_t acc
  );
    if (!acc.we && (acc.addr == pbw_pkg::ADDR_ASYNC_SERIAL0_RX_STATUS ||
        acc.addr == pbw_pkg::ADDR_ASYNC_SERIAL6_RX_STATUS ||
        acc.addr == pbw_pkg::ADDR_TWO_WIRE_SERIAL_STATUS)) begin
      classify = pbw_pkg::KIND_FIXED;
    end else begin
      classify = pbw_pkg::KIND_HSK;
    end
  endfunction

  function automatic logic is_conv_write(input pbw_pkg::pbw_access_t acc);
    is_conv_write = acc.we && (acc.addr == pbw_pkg::ADDR_CONVERTER_MODE_REG);
  endfunction

  // resynchronise everything coming from the peripheral clock domain
  pbw_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in({per_ack_tgl, per_rdata, async_serial0_rx_status,
               async_serial6_rx_status, two_wire_serial_status}),
    .sync_out({ack_s, rdata_s, stat0_s, stat6_s, stat_tw_s})
  ); // [RULE_02]

  assign kind = classify(cpu_acc);
  assign ack_new = (ack_s != ack_seen); // [RULE_07]

  // wait is held until the access is ready, processor stalls meanwhile
  assign cpu_ready = (state == ST_FIXED) || (state == ST_DONE); // [RULE_03]
  assign cpu_wait = cpu_req && !cpu_ready; // [RULE_04]

  // access sequencing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cpu_req && kind == pbw_pkg::KIND_FIXED) begin
            state <= ST_FIXED; // [RULE_05]
          end else if (cpu_req) begin
            state <= ST_HSK; // [RULE_01]
          end
        end
        ST_FIXED: begin
          state <= ST_IDLE;
        end
        ST_HSK: begin
          if (ack_new) begin
            state <= ST_DONE; // [RULE_07]
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // peripheral request toggle and held access
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      per_req_tgl <= 1'b0;
      per_acc <= '0;
    end else if (state == ST_IDLE && cpu_req &&
                 kind == pbw_pkg::KIND_HSK) begin
      per_req_tgl <= !per_req_tgl; // [RULE_01]
      per_acc <= cpu_acc;
    end
  end

  // acknowledge tracking
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_seen <= 1'b0;
    end else if (state == ST_HSK && ack_new) begin
      ack_seen <= ack_s;
    end
  end

  // read data only from resynchronised, settled values
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata <= pbw_pkg::DATA_ZERO;
    end else if (state == ST_IDLE && cpu_req &&
                 kind == pbw_pkg::KIND_FIXED) begin
      case (cpu_acc.addr)
        pbw_pkg::ADDR_ASYNC_SERIAL0_RX_STATUS: cpu_rdata <= stat0_s;
        pbw_pkg::ADDR_ASYNC_SERIAL6_RX_STATUS: cpu_rdata <= stat6_s;
        default: cpu_rdata <= stat_tw_s;
      endcase // [RULE_05]
    end else if (state == ST_HSK && ack_new && !per_acc.we) begin
      cpu_rdata <= rdata_s; // [RULE_03]
    end
  end

  // wait clock counting of the current access
  always_comb begin
    next_wait_run = wait_run;
    if (cpu_ready) begin
      next_wait_run = pbw_pkg::WAIT_ZERO;
    end else if (cpu_wait && wait_run != pbw_pkg::WAIT_SAT) begin
      next_wait_run = wait_run + pbw_pkg::WAIT_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_run <= pbw_pkg::WAIT_ZERO;
    end else begin
      wait_run <= next_wait_run;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      last_wait <= pbw_pkg::WAIT_ZERO;
    end else if (cpu_ready) begin
      last_wait <= wait_run; // [RULE_04]
    end
  end

  // converter mode write bound check
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_access <= 1'b0;
    end else if (state == ST_IDLE && cpu_req) begin
      conv_access <= is_conv_write(cpu_acc);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conv_wait_overrun <= 1'b0;
    end else if (cpu_ready && conv_access) begin
      conv_wait_overrun <= (wait_run > pbw_pkg::CONV_WAIT_MAX) ||
                           (wait_run < pbw_pkg::CONV_WAIT_MIN); // [RULE_06]
    end
  end

  // checks
  property p_fixed_one;
    @(posedge clk_sys) disable iff (!rstn)
    (state == ST_IDLE && cpu_req && kind == pbw_pkg::KIND_FIXED) |=>
      cpu_ready && wait_run == pbw_pkg::FIXED_WAIT;
  endproperty
  fixed_read_wait_a: assert property (p_fixed_one) // [RULE_05]
    else $error("fixed status read did not take one wait clock");

  fixed_read_data_a: assert property ( // [RULE_05]
    (state == ST_IDLE && cpu_req &&
     cpu_acc.addr == pbw_pkg::ADDR_ASYNC_SERIAL0_RX_STATUS && !cpu_acc.we)
    |=> cpu_rdata == $past(stat0_s))
    else $error("status read returned wrong data");

  hsk_req_toggle_a: assert property ( // [RULE_01]
    (state == ST_IDLE && cpu_req && kind == pbw_pkg::KIND_HSK) |=>
      per_req_tgl != $past(per_req_tgl) && state == ST_HSK)
    else $error("peripheral request not issued");

  hsk_release_a: assert property ( // [RULE_07]
    (state == ST_HSK && !ack_new) |=> !cpu_ready)
    else $error("wait released before synchronised acknowledge");

  hsk_done_a: assert property ( // [RULE_03]
    (state == ST_HSK && ack_new) |=> cpu_ready ##1 state == ST_IDLE)
    else $error("access not completed after acknowledge");

  hsk_rdata_a: assert property ( // [RULE_02]
    (state == ST_HSK && ack_new && !per_acc.we) |=>
      cpu_rdata == $past(rdata_s))
    else $error("handshake read data not taken from synchronised bus");

  wait_count_a: assert property ( // [RULE_04]
    cpu_ready |=> last_wait == $past(wait_run))
    else $error("wait count of access not recorded");

  wait_stall_a: assert property ( // [RULE_04]
    (cpu_wait && state != ST_IDLE) |=>
      $stable(per_req_tgl) && $stable(per_acc))
    else $error("new transfer started during wait");

  conv_range_a: assert property ( // [RULE_06]
    (cpu_ready && conv_access && wait_run >= pbw_pkg::CONV_WAIT_MIN &&
     wait_run <= pbw_pkg::CONV_WAIT_MAX) |=> !conv_wait_overrun)
    else $error("converter write flagged despite legal wait");

  fixed_read_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    state == ST_FIXED);
  hsk_read_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    state == ST_DONE && !per_acc.we);
  conv_write_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    cpu_ready && conv_access);
  back_to_back_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    cpu_ready ##1 cpu_req ##1 cpu_ready);
endmodule // pbw_bridge
`default_nettype wire

// ==== sim/pbw_per_model.sv ====
// peripheral side model answering bridge transfers on its own clock
`timescale 1ns/1ps
`default_nettype none
module pbw_per_model (
  // reset
  input wire logic rstn,
  // request from the bridge
  input wire logic per_req_tgl,
  input wire pbw_pkg::pbw_access_t per_acc,
  input wire logic [2:0] dly,
  // answer
  output logic per_ack_tgl,
  output logic [pbw_pkg::DATA_W-1:0] per_rdata
);
  logic clk_per;
  logic seen;
  logic [2:0] cnt;
  logic [pbw_pkg::DATA_W-1:0] answer;
  assign answer = per_acc.addr[7:0] ^ per_acc.addr[15:8] ^ 8'h3c;
  initial begin
    clk_per = 1'b0;
    forever #18.5 clk_per = ~clk_per;
  end
  // data is junk until one edge before the ack, then held until next request
  always_ff @(posedge clk_per or negedge rstn) begin
    if (!rstn) begin
      per_ack_tgl <= 1'b0;
      seen <= 1'b0;
      cnt <= 3'h0;
      per_rdata <= 8'h00;
    end else if (per_req_tgl != seen) begin
      seen <= per_req_tgl;
      cnt <= dly;
      if (dly == 3'h0) begin
        per_rdata <= answer;
      end else begin
        per_rdata <= ~per_rdata;
      end
    end else if (per_ack_tgl != seen) begin
      if (cnt == 3'h0) begin
        per_ack_tgl <= seen;
      end else begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1) begin
          per_rdata <= answer;
        end
      end
    end
  end
endmodule // pbw_per_model
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench of the bridge with a peripheral model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  typedef struct {
    logic [7:0] rd;
    logic [1:0] kind;
    pbw_pkg::pbw_access_t acc;
  } pbw_note_t;
  logic clk_sys, rstn, cpu_req, cpu_wait, cpu_ready, conv_wait_overrun;
  logic per_req_tgl, per_ack_tgl;
  pbw_pkg::pbw_access_t cpu_acc, per_acc;
  logic [7:0] cpu_rdata, last_wait, per_rdata, st0, st6, st2, wcnt;
  logic [2:0] dly;
  logic lw_pend, ovr_exp;
  int error_cnt, checked;
  logic [31:0] rnd;
  pbw_note_t q[$];
  pbw_note_t nt;
  pbw_bridge pbw_bridge_inst (.clk_sys(clk_sys), .rstn(rstn),
    .cpu_req(cpu_req), .cpu_acc(cpu_acc), .cpu_wait(cpu_wait),
    .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata), .last_wait(last_wait),
    .conv_wait_overrun(conv_wait_overrun), .per_req_tgl(per_req_tgl),
    .per_acc(per_acc), .per_ack_tgl(per_ack_tgl), .per_rdata(per_rdata),
    .async_serial0_rx_status(st0), .async_serial6_rx_status(st6),
    .two_wire_serial_status(st2));
  pbw_per_model pbw_per_model_inst (.rstn(rstn), .per_req_tgl(per_req_tgl),
    .per_acc(per_acc), .dly(dly), .per_ack_tgl(per_ack_tgl),
    .per_rdata(per_rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one access: request held until ready, then the next edge
  task automatic run(input logic [15:0] a, input logic we,
                     input logic [7:0] rd, input logic [1:0] kind);
    int i;
    cpu_acc = '{addr: a, we: we, wdata: rnd[15:8]};
    q.push_back('{rd: rd, kind: kind, acc: cpu_acc});
    cpu_req = 1'b1;
    for (i = 0; i < 200 && cpu_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 200) begin
      error_cnt++;
      wrap_up();
    end
    @(posedge clk_sys);
    #1;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // watcher: counts wait cycles and compares each completion
  always @(negedge clk_sys) begin
    if (lw_pend) begin
      `CHK(last_wait, wcnt)
      ovr_exp = (wcnt > pbw_pkg::CONV_WAIT_MAX) ||
                (wcnt < pbw_pkg::CONV_WAIT_MIN);
      if (nt.kind == 2'h2) `CHK(conv_wait_overrun, ovr_exp)
      lw_pend = 1'b0;
      wcnt = 8'h00;
    end
    if (cpu_wait === 1'b1) wcnt++;
    if (cpu_ready === 1'b1) begin
      if (q.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        nt = q.pop_front();
        if (!nt.acc.we) `CHK(cpu_rdata, nt.rd)
        if (nt.kind == 2'h0) `CHK(wcnt, 8'h01)
        else begin
          `CHK(per_ack_tgl, per_req_tgl)
          `CHK(per_acc, nt.acc)
          `CHK(wcnt >= 8'h04, 1'b1)
        end
        lw_pend = 1'b1;
      end
    end
  end
  initial begin
    logic [15:0] a;
    error_cnt = 0;
    checked = 0;
    lw_pend = 1'b0;
    wcnt = 8'h00;
    rnd = 32'h5691;
    rstn = 1'b0;
    cpu_req = 1'b0;
    cpu_acc = '0;
    dly = 3'h0;
    st0 = rnd[7:0];
    st6 = rnd[15:8];
    st2 = rnd[7:0] ^ rnd[15:8];
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    run(pbw_pkg::ADDR_ASYNC_SERIAL0_RX_STATUS, 1'b0, st0, 2'h0);
    run(pbw_pkg::ADDR_ASYNC_SERIAL6_RX_STATUS, 1'b0, st6, 2'h0);
    run(pbw_pkg::ADDR_TWO_WIRE_SERIAL_STATUS, 1'b0, st2, 2'h0);
    repeat (16) begin
      rnd = lfsr(rnd);
      a = {8'h10, rnd[7:0]};
      dly = rnd[11:9];
      run(a, rnd[8], a[7:0] ^ a[15:8] ^ 8'h3c, 2'h1);
    end
    for (int d = 0; d < 8; d++) begin
      rnd = lfsr(rnd);
      dly = d[2:0];
      run(pbw_pkg::ADDR_CONVERTER_MODE_REG, 1'b1, 8'h00, 2'h2);
    end
    cpu_req = 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK(q.size(), 0)
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
